//--- verilog/pio_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "pio_map.svh"
// parallel port block: three bidirectional ports, one input-only port
module pio_top
(
   // clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   // avalon-mm slave
   input wire logic [5:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // bidirectional pins, index 0 = A, 1 = B, 2 = C
   input wire logic [2:0][7:0] port_pins_i,
   output logic [2:0][7:0] port_pins_o,
   output logic [2:0][7:0] port_pins_oe_o,
   // input-only port D
   input wire logic [7:0] port_d_lines_i,
   output logic [7:0] port_d_analog_o,
   // clock output control and converter
   input wire logic clock_output_select_i,
   input wire logic conversion_complete_flag_i,
   output logic converter_enable_o,
   output logic converter_rc_clock_select_o,
   output logic [3:0] channel_select_o
);
   import pio_pkg::*;

   pio_bus_state_e state;
   logic [3:0] index;
   logic access;
   logic wr_ok;
   pio_byte_t conv_ctrl;
   pio_byte_t port_d_inputs;
   pio_byte_t read_byte;
   logic [31:0] next_readdata;
   pio_byte_t port_view [3];
   pio_byte_t dir_eff [3];

   pio_port_if pif [3] ();

   // byte address is four times the index; the two low address bits select nothing
   assign index = avs_address[5:2];
   assign access = avs_read || avs_write;
   assign wr_ok = avs_write && (state == PIO_IDLE) && avs_byteenable[0];

   // each access stalls one cycle, then completes; keeps read data registered
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         state <= PIO_IDLE;
      end
      else
      begin
         unique case (state)
            PIO_IDLE: if (access) state <= PIO_ANSWER;
            PIO_ANSWER: state <= PIO_IDLE;
         endcase
      end
   end
   assign avs_waitrequest = access && (state == PIO_IDLE);

   // one slice per bidirectional port
   generate
      for (genvar p = 0; p < 3; p++)
      begin : g_port
         assign pif[p].latch_we = wr_ok && (index == 4'(p));
         assign pif[p].dir_we = wr_ok && (index == 4'(p) + 4'h4);
         assign pif[p].wdata = avs_writedata[7:0];
         pio_port_slice u_slice
         (
            .clk_i(clk_i),
            .resetn_i(resetn_i),
            .bus(pif[p].ctrl)
         );
         // clock mode forces line two of port C to output; the select bit lives outside
         // and is cleared by the same reset, so no copy is kept here to go stale
         always_comb
         begin
            dir_eff[p] = pif[p].dir;
            if (p == 2 && clock_output_select_i)
            begin
               dir_eff[p][`PIO_CLOCK_LINE] = 1'b1;
            end
         end
         // pin drive and readback per bit
         for (genvar b = 0; b < 8; b++)
         begin : g_bit
            if (p == 2 && b == `PIO_CLOCK_LINE)
            begin : g_clk
               // the clock leaves combinationally; a flop could not follow clk itself
               assign port_pins_o[p][b] = clock_output_select_i ? clk_i : pif[p].latch[b];
            end
            else
            begin : g_std
               assign port_pins_o[p][b] = pif[p].latch[b];
            end
            assign port_pins_oe_o[p][b] = dir_eff[p][b];
            // output pins read the latch, inputs read the pin
            assign port_view[p][b] = dir_eff[p][b] ? pif[p].latch[b]
                                                   : port_pins_i[p][b];
         end
      end
   endgenerate

   // port D digital path is blanked while the converter owns the pins
   assign port_d_inputs = conv_ctrl[`PIO_CONV_ENABLE_BIT] ? 8'h00 : port_d_lines_i;
   assign port_d_analog_o = conv_ctrl[`PIO_CONV_ENABLE_BIT] ? port_d_lines_i : 8'h00;

   // converter control bits; completion flag is the converter's, bit 4 reads zero
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         conv_ctrl <= `PIO_CONV_RESET;
      end
      else if (wr_ok && index == `PIO_IDX_CONV_CTRL)
      begin
         conv_ctrl <= avs_writedata[7:0] & `PIO_CONV_WRITE_MASK;
      end
   end
   assign converter_enable_o = conv_ctrl[`PIO_CONV_ENABLE_BIT];
   assign converter_rc_clock_select_o = conv_ctrl[`PIO_CONV_RC_BIT];
   assign channel_select_o = conv_ctrl[3:0];

   // read multiplexer
   always_comb
   begin
      read_byte = 8'h00;
      unique case (index)
         `PIO_IDX_LATCH_A: read_byte = port_view[0];
         `PIO_IDX_LATCH_B: read_byte = port_view[1];
         `PIO_IDX_LATCH_C: read_byte = port_view[2];
         `PIO_IDX_INPUTS_D: read_byte = port_d_inputs;
         `PIO_IDX_DIR_A: read_byte = pif[0].dir;
         `PIO_IDX_DIR_B: read_byte = pif[1].dir;
         `PIO_IDX_DIR_C: read_byte = pif[2].dir;
         `PIO_IDX_CONV_CTRL: read_byte = {conversion_complete_flag_i, conv_ctrl[6:0]};
         default: read_byte = 8'h00;
      endcase
      next_readdata = {24'h000000, read_byte};
   end

   // read data registered in the stall cycle, stands at the completing edge
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         avs_readdata <= `PIO_UNMAPPED_DATA;
      end
      else if (avs_read && state == PIO_IDLE)
      begin
         avs_readdata <= next_readdata;
      end
   end
endmodule : pio_top
`default_nettype wire

//--- verilog/pio_map.svh
// Behaviour
// - three 8-bit bidirectional ports, one input-only
// - direction bit one drives, zero listens
// - reset clears all direction registers
// - reset leaves output latches untouched
// - write with direction zero updates latch only
// - write with direction one drives pin
// - read with direction zero returns pin
// - read with direction one returns latch
// - direction registers read back last write
// - clock select drives cpu clock on C2
// - clock select cleared by reset, kept otherwise; the code takes it as input clock_output_select_i and keeps no copy
// - port D input-only, always readable; the code reads zero while converter enable is set
// - converter enable hands port D to converter
// - reset clears converter status/control register; bit 7 reads conversion_complete_flag_i, which reset does not clear
// - open-drain emulation by toggling direction bit
`ifndef PIO_MAP_SVH
`define PIO_MAP_SVH
// printed offsets are register indices; byte address is four times the index
`define PIO_IDX_LATCH_A 4'h0
`define PIO_IDX_LATCH_B 4'h1
`define PIO_IDX_LATCH_C 4'h2
`define PIO_IDX_INPUTS_D 4'h3
`define PIO_IDX_DIR_A 4'h4
`define PIO_IDX_DIR_B 4'h5
`define PIO_IDX_DIR_C 4'h6
`define PIO_IDX_CONV_CTRL 4'h9
`define PIO_DIR_RESET 8'h00
`define PIO_CONV_RESET 8'h00
`define PIO_CONV_ENABLE_BIT 5
`define PIO_CONV_ZERO_BIT 4
`define PIO_CONV_RC_BIT 6
`define PIO_CONV_WRITE_MASK 8'h6F
`define PIO_CLOCK_LINE 2
`define PIO_UNMAPPED_DATA 32'h00000000
`endif

//--- verilog/pio_pkg.sv
`default_nettype none
package pio_pkg;
   typedef logic [7:0] pio_byte_t;
   typedef enum logic [1:0] {PIO_PORT_A, PIO_PORT_B, PIO_PORT_C} pio_port_e;
   typedef enum {PIO_IDLE, PIO_ANSWER} pio_bus_state_e;
endpackage : pio_pkg
`default_nettype wire

//--- verilog/pio_port_if.sv
`timescale 1ns/1ps
`default_nettype none
// write strobe, data and readback between the bus slave and one port slice
interface pio_port_if;
   import pio_pkg::*;
   logic latch_we;
   logic dir_we;
   pio_byte_t wdata;
   pio_byte_t latch;
   pio_byte_t dir;
   modport ctrl (output latch_we, output dir_we, output wdata, input latch, input dir);
   modport port (input latch_we, input dir_we, input wdata, output latch, output dir);
endinterface : pio_port_if
`default_nettype wire

//--- verilog/pio_port_slice.sv
`timescale 1ns/1ps
`default_nettype none
`include "pio_map.svh"
// one bidirectional port: output latch and direction register
module pio_port_slice
(
   // clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   // register side
   pio_port_if.port bus
);
   import pio_pkg::*;

   // latch has no reset so its content survives a reset
   always_ff @(posedge clk_i)
   begin
      if (bus.latch_we)
      begin
         bus.latch <= bus.wdata;
      end
   end

   // direction register, cleared by reset
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         bus.dir <= `PIO_DIR_RESET;
      end
      else if (bus.dir_we)
      begin
         bus.dir <= bus.wdata;
      end
   end
endmodule : pio_port_slice
`default_nettype wire

//--- bench/pio_pins_model.sv
`timescale 1ns/1ps
`default_nettype none
// outside circuitry: a driven line shows the block's level, an undriven one the source
module pio_pins_model
(
   // block side
   input wire logic [2:0][7:0] out_i,
   input wire logic [2:0][7:0] oe_i,
   // outside source level and resolved pins
   input wire logic [7:0] ext_i,
   output logic [2:0][7:0] pins_o
);
   // released lines follow the source, never the last driven value
   always_comb
   begin
      for (int p = 0; p < 3; p++)
      begin
         pins_o[p] = (out_i[p] & oe_i[p]) | (ext_i & ~oe_i[p]);
      end
   end
endmodule : pio_pins_model
`default_nettype wire

//--- bench/pio_top_chk.sv
`timescale 1ns/1ps
`default_nettype none
// watches the port block at its bus and pins
module pio_top_chk
(
   // watched ports
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic [5:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   input wire logic avs_waitrequest,
   input wire logic [2:0][7:0] port_pins_o,
   input wire logic [2:0][7:0] port_pins_oe_o,
   input wire logic [7:0] port_d_lines_i,
   input wire logic [7:0] port_d_analog_o,
   input wire logic clock_output_select_i,
   input wire logic converter_enable_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!resetn_i);
   // a write has landed once its wait cycle is over
   wire logic wr_done = avs_write && !avs_waitrequest && avs_byteenable[0];
   a_dir_reset: assert property ($rose(resetn_i) |-> port_pins_oe_o == '0)
      else $error("pins driven after reset");
   a_clk_dir: assert property (clock_output_select_i |-> port_pins_oe_o[2][2])
      else $error("clock line not driven");
   a_clk_out_low: assert property (clock_output_select_i |-> !port_pins_o[2][2])
      else $error("clock line high before rising edge");
   a_clk_out_high: assert property (@(negedge clk_i) clock_output_select_i |-> port_pins_o[2][2])
      else $error("clock line low before falling edge");
   a_conv_pass: assert property (converter_enable_o |-> port_d_analog_o == port_d_lines_i)
      else $error("converter inputs not passed");
   a_conv_off: assert property (!converter_enable_o |-> port_d_analog_o == 8'h00)
      else $error("converter inputs live while off");
   a_wait_first: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
      else $error("no wait cycle");
   a_wait_bound: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("answer late");
   a_dir_write: assert property (wr_done && avs_address[5:2] == 4'h4 |->
      port_pins_oe_o[0] == avs_writedata[7:0]) else $error("direction write lost");
   a_latch_drive: assert property (wr_done && avs_address[5:2] == 4'h0 |->
      port_pins_o[0] == avs_writedata[7:0]) else $error("latch write lost");
endmodule : pio_top_chk
`default_nettype wire

//--- bench/parallel_io_ports_tb.sv
`timescale 1ns/1ps
`default_nettype none
module parallel_io_ports_tb;
   typedef struct {logic [5:0] wa; logic [7:0] wd; logic [5:0] ra; logic [7:0] ex;} pio_row_s;
   logic clk_i = 0, resetn_i = 0, avs_read = 0, avs_write = 0, clock_output_select_i = 0;
   logic [5:0] avs_address = '0;
   logic [31:0] avs_writedata = '0, avs_readdata;
   logic avs_waitrequest;
   logic [2:0][7:0] port_pins_i, port_pins_o, port_pins_oe_o;
   logic [7:0] port_d_lines_i = 8'hA5, rd;
   logic conversion_complete_flag_i = 0, converter_enable_o, converter_rc_clock_select_o;
   logic [3:0] channel_select_o;
   logic [7:0] port_d_analog_o;
   int err_total = 0, n_checks = 0, cycles = 0;
   // write address/data, read address, expected byte; outside pins sit at 8'h33
   pio_row_s rows [8] = '{'{6'h00, 8'h5A, 6'h00, 8'h33}, '{6'h10, 8'h0F, 6'h00, 8'h3A},
      '{6'h04, 8'h00, 6'h04, 8'h33},
      '{6'h14, 8'hC3, 6'h14, 8'hC3}, '{6'h3C, 8'hFF, 6'h3C, 8'h00},
      '{6'h24, 8'hFF, 6'h24, 8'h6F}, '{6'h24, 8'hFF, 6'h0C, 8'h00},
      '{6'h24, 8'h00, 6'h0C, 8'hA5}};
   always #12.5 clk_i = ~clk_i;
   pio_top DUT (.clk_i, .resetn_i, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest, .port_pins_i, .port_pins_o,
      .port_pins_oe_o, .port_d_lines_i, .port_d_analog_o, .clock_output_select_i,
      .conversion_complete_flag_i, .converter_enable_o, .converter_rc_clock_select_o,
      .channel_select_o);
   pio_pins_model u_pins (.out_i(port_pins_o), .oe_i(port_pins_oe_o), .ext_i(8'h33),
      .pins_o(port_pins_i));
   task automatic report_and_stop();
      $display("checks=%0d mismatches=%0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : report_and_stop
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // one bus cycle; an idle edge first keeps back-to-back calls from colliding
   task automatic xfer(input logic r, input logic [5:0] a, input logic [7:0] w);
      @(posedge clk_i);
      avs_read <= r;
      avs_write <= !r;
      avs_address <= a;
      avs_writedata <= {24'h0, w};
      do @(posedge clk_i); while (avs_waitrequest !== 1'b0);
      rd = avs_readdata[7:0];
      avs_read <= 0;
      avs_write <= 0;
   endtask : xfer
   // hang guard
   always @(posedge clk_i)
   begin
      cycles++;
      if (cycles == 2000)
      begin
         err_total++;
         report_and_stop();
      end
   end
   initial
   begin
      repeat (4) @(posedge clk_i);
      resetn_i <= 1;
      foreach (rows[i])
      begin
         xfer(0, rows[i].wa, rows[i].wd);
         xfer(1, rows[i].ra, 8'h00);
         chk(rd, rows[i].ex);
      end
      chk({port_pins_oe_o[0], port_pins_o[0]}, 16'h0F5A);
      $display("table done");
      xfer(0, 6'h04, 8'h00);
      xfer(0, 6'h14, 8'h01);
      chk(port_pins_i[1][0], 1'b0);
      xfer(0, 6'h14, 8'h00);
      chk(port_pins_i[1][0], 1'b1);
      $display("open drain done");
      xfer(0, 6'h08, 8'h04);
      xfer(0, 6'h18, 8'h00);
      clock_output_select_i <= 1;
      xfer(1, 6'h08, 8'h00);
      chk({port_pins_oe_o[2], rd}, 16'h0437);
      $display("clock line done");
      xfer(0, 6'h24, 8'hFF);
      conversion_complete_flag_i <= 1;
      xfer(1, 6'h24, 8'h00);
      chk(rd, 8'hEF);
      chk({converter_enable_o, converter_rc_clock_select_o, channel_select_o}, 6'h3F);
      chk(port_d_analog_o, 8'hA5);
      clock_output_select_i <= 0;
      conversion_complete_flag_i <= 0;
      resetn_i <= 0;
      @(posedge clk_i);
      chk(port_pins_oe_o, 24'h0);
      chk({converter_enable_o, port_d_analog_o}, 9'h000);
      resetn_i <= 1;
      xfer(1, 6'h24, 8'h00);
      chk(rd, 8'h00);
      xfer(0, 6'h10, 8'hFF);
      xfer(1, 6'h00, 8'h00);
      chk(rd, 8'h5A);
      $display("reset done");
      report_and_stop();
   end
endmodule : parallel_io_ports_tb
bind pio_top pio_top_chk u_chk (.clk_i, .resetn_i, .avs_address, .avs_read, .avs_write,
   .avs_writedata, .avs_byteenable, .avs_waitrequest, .port_pins_o, .port_pins_oe_o,
   .port_d_lines_i, .port_d_analog_o, .clock_output_select_i, .converter_enable_o);
`default_nettype wire
